// ===== hdl/hex_image_checker.v
/*
 * Programmer-side image checker. Consumes a stream of image bytes tagged with
 * file addresses, classifies each by section, sums the application bytes,
 * parses metadata, matches silicon identity, decides fuse blows and orders
 * bank operations. Assumes the byte stream and target readbacks come from
 * logic on core_clk; the debug link itself lives elsewhere.
 */
`timescale 1ns/1ps
`include "image_check_defs.vh"

// Contract
// - App section maps directly, max 2 MB
// - Auxiliary flash optional, max 32 KB, direct
// - Supervisory flash optional, up to five fragments
// - External section optional, max 128 MB
// - Checksum is low two bytes, MSB first
// - Verify target sum and file sum
// - Metadata twelve bytes, never programmed
// - Version big-endian, must be five
// - Silicon ID: high, low, revision, family
// - Match ID bytes and family, skip revision
// - Reserved and internal metadata bytes ignored
// - One file byte per fuse bit
// - Fuse codes unblown, blown, ignore
// - Blow only unblown bit marked blown
// - Program internal banks before external
// - Erase external bank before internal banks
// - External data inside execute-in-place window
// - Boot table points to config in flash
// - Buffer by file address, translate after
module hex_image_checker (
   core_clk,
   sys_rst,
   img_valid,
   img_addr,
   img_byte,
   img_last,
   target_id,
   tgt_sum_valid,
   tgt_sum,
   fuse_rd_valid,
   fuse_rd_idx,
   fuse_rd_bit,
   op_start,
   op_erase,
   bank_done,
   sec_code,
   tgt_addr,
   tgt_we,
   tgt_data,
   fuse_blow,
   fuse_blow_idx,
   bank_req,
   bank_sel,
   image_ok,
   id_ok,
   csum_ok,
   verify_ok,
   mismatch,
   range_err,
   version_err,
   file_csum,
   app_csum,
   done
);
   input  wire        core_clk;
   input  wire        sys_rst;
   input  wire        img_valid;
   input  wire [31:0] img_addr;
   input  wire [7:0]  img_byte;
   input  wire        img_last;
   input  wire [31:0] target_id;
   input  wire        tgt_sum_valid;
   input  wire [15:0] tgt_sum;
   input  wire        fuse_rd_valid;
   input  wire [11:0] fuse_rd_idx;
   input  wire        fuse_rd_bit;
   input  wire        op_start;
   input  wire        op_erase;
   input  wire        bank_done;
   output reg  [2:0]  sec_code;
   output reg  [31:0] tgt_addr;
   output reg         tgt_we;
   output reg  [7:0]  tgt_data;
   output reg         fuse_blow;
   output reg  [11:0] fuse_blow_idx;
   output reg         bank_req;
   output reg  [1:0]  bank_sel;
   output reg         image_ok;
   output reg         id_ok;
   output reg         csum_ok;
   output reg         verify_ok;
   output reg         mismatch;
   output reg         range_err;
   output reg         version_err;
   output reg  [15:0] file_csum;
   output reg  [15:0] app_csum;
   output reg         done;

   localparam SEC_NONE = 3'h0;
   localparam SEC_APP  = 3'h1;
   localparam SEC_AUX  = 3'h2;
   localparam SEC_SUP  = 3'h3;
   localparam SEC_EXT  = 3'h4;
   localparam SEC_CSUM = 3'h5;
   localparam SEC_META = 3'h6;
   localparam SEC_FUSE = 3'h7;
   localparam BANK_INT = 2'h1;
   localparam BANK_EXT = 2'h2;
   localparam ST_IDLE  = 3'h0;
   localparam ST_PINT  = 3'h1;
   localparam ST_PEXT  = 3'h2;
   localparam ST_EEXT  = 3'h3;
   localparam ST_EINT  = 3'h4;
   localparam ST_DONE  = 3'h5;
   // Section decode from file address
   reg [2:0]  sec_nxt;
   reg [31:0] ofs_nxt;
   always @* begin
      sec_nxt = SEC_NONE;
      ofs_nxt = 32'h00000000;
      if (img_addr >= `SEC_FUSE_BASE && img_addr < `SEC_FUSE_BASE + `SEC_FUSE_MAX) begin
         sec_nxt = SEC_FUSE;
         ofs_nxt = img_addr - `SEC_FUSE_BASE;
      end else if (img_addr >= `SEC_META_BASE && img_addr < `SEC_META_BASE + `SEC_META_LEN) begin
         sec_nxt = SEC_META;
         ofs_nxt = img_addr - `SEC_META_BASE;
      end else if (img_addr >= `SEC_CSUM_BASE && img_addr < `SEC_CSUM_BASE + 32'h2) begin
         sec_nxt = SEC_CSUM;
         ofs_nxt = img_addr - `SEC_CSUM_BASE;
      end else if (img_addr >= `SEC_EXT_BASE && img_addr <= `SEC_EXT_END) begin
         sec_nxt = SEC_EXT;
         ofs_nxt = img_addr - `SEC_EXT_BASE;
      end else if (img_addr >= `SEC_SUP_BASE && img_addr <= `SEC_SUP_END) begin
         sec_nxt = SEC_SUP;
         ofs_nxt = img_addr - `SEC_SUP_BASE;
      end else if (img_addr >= `SEC_AUX_BASE && img_addr < `SEC_SUP_BASE) begin
         sec_nxt = SEC_AUX;
         ofs_nxt = img_addr - `SEC_AUX_BASE;
      end else if (img_addr >= `SEC_APP_BASE && img_addr < `SEC_AUX_BASE) begin
         sec_nxt = SEC_APP;
         ofs_nxt = img_addr - `SEC_APP_BASE;
      end
   end

   // Out-of-range byte within a known section, or a byte outside every section
   reg oor_nxt;
   always @* begin
      case (sec_nxt)
         SEC_APP:  oor_nxt = (ofs_nxt >= `SEC_APP_MAX);
         SEC_AUX:  oor_nxt = (ofs_nxt >= `SEC_AUX_MAX);
         SEC_EXT:  oor_nxt = (ofs_nxt >= `SEC_EXT_MAX);
         SEC_NONE: oor_nxt = 1'b1;
         default:  oor_nxt = 1'b0;
      endcase
   end

   // Supervisory fragments: a new fragment starts on any address gap
   reg [31:0] sup_last_r;
   reg        sup_seen_r;
   reg [2:0]  sup_frags_r;
   wire       sup_new = (sec_nxt == SEC_SUP) &&
                        (!sup_seen_r || img_addr != sup_last_r + 32'h1);
   wire       sup_refuse = (sec_nxt == SEC_SUP) && ((sup_frags_r > `SUP_FRAG_MAX) ||
                           (sup_new && sup_frags_r == `SUP_FRAG_MAX));

   // Metadata store
   reg        meta_rd_phase_r;
   reg [3:0]  meta_rd_idx_r;
   wire [7:0] meta_rd_data;
   meta_store u_meta (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .wr_en    (img_valid && sec_nxt == SEC_META),
      .wr_idx   (ofs_nxt[3:0]),
      .wr_data  (img_byte),
      .rd_idx   (meta_rd_idx_r),
      .rd_data  (meta_rd_data)
   );

   reg [15:0] version_r;
   reg [31:0] file_id_r;
   reg [3:0]  meta_cnt_r;
   reg        parsed_r;
   reg        fuse_pending_r;
   reg [7:0]  fuse_code_r [0:0];
   reg [2:0]  state_r;
   reg [2:0]  state_nxt;

   // Per-byte stream handling
   always @(posedge core_clk) begin
      if (sys_rst) begin
         sec_code    <= SEC_NONE;
         tgt_addr    <= 32'h00000000;
         tgt_we      <= 1'b0;
         tgt_data    <= 8'h00;
         app_csum    <= 16'h0000;
         file_csum   <= 16'h0000;
         range_err   <= 1'b0;
         sup_last_r  <= 32'h00000000;
         sup_seen_r  <= 1'b0;
         sup_frags_r <= 3'h0;
      end else begin
         tgt_we <= 1'b0;
         if (img_valid) begin
            sec_code <= sec_nxt;
            tgt_data <= img_byte;
            tgt_addr <= img_addr;
            tgt_we   <= (sec_nxt == SEC_APP || sec_nxt == SEC_AUX || sec_nxt == SEC_SUP ||
                         sec_nxt == SEC_EXT) && !oor_nxt && !sup_refuse;
            if (sec_nxt == SEC_APP && !oor_nxt) begin
               app_csum <= app_csum + {8'h00, img_byte};
            end
            if (sec_nxt == SEC_CSUM) begin
               if (ofs_nxt[0] == 1'b0) begin
                  file_csum[15:8] <= img_byte;
               end else begin
                  file_csum[7:0] <= img_byte;
               end
            end
            if (sec_nxt == SEC_SUP) begin
               sup_last_r <= img_addr;
               sup_seen_r <= 1'b1;
               if (sup_new && sup_frags_r != 3'h7) begin
                  sup_frags_r <= sup_frags_r + 3'h1;
               end
            end
            if (oor_nxt || sup_refuse) begin
               range_err <= 1'b1;
            end
         end
      end
   end

   // Metadata parse after the last image byte; walks the twelve bytes
   always @(posedge core_clk) begin
      if (sys_rst) begin
         meta_rd_phase_r <= 1'b0;
         meta_rd_idx_r   <= 4'h0;
         meta_cnt_r      <= 4'h0;
         version_r       <= 16'h0000;
         file_id_r       <= 32'h00000000;
         parsed_r        <= 1'b0;
      end else if (img_valid && img_last && !meta_rd_phase_r) begin
         meta_rd_phase_r <= 1'b1;
         meta_rd_idx_r   <= 4'h0;
         meta_cnt_r      <= 4'h0;
         parsed_r        <= 1'b0;
      end else if (meta_rd_phase_r) begin
         meta_rd_idx_r <= meta_rd_idx_r + 4'h1;
         meta_cnt_r    <= meta_rd_idx_r;
         if (meta_rd_idx_r != 4'h0) begin
            // Read data lags the index by one cycle
            case (meta_cnt_r)
               4'h0: version_r[15:8] <= meta_rd_data;
               4'h1: version_r[7:0]  <= meta_rd_data;
               4'h2: file_id_r[31:24] <= meta_rd_data;
               4'h3: file_id_r[23:16] <= meta_rd_data;
               4'h4: file_id_r[15:8]  <= meta_rd_data;
               4'h5: file_id_r[7:0]   <= meta_rd_data;
               default: ; // Reserved and internal-use bytes are skipped
            endcase
         end
         if (meta_rd_idx_r == `META_OFS_INT + 4'h3 + 4'h1) begin
            meta_rd_phase_r <= 1'b0;
            parsed_r        <= 1'b1;
         end
      end else begin
         parsed_r <= 1'b0;
      end
   end

   // Verdicts, registered once metadata is parsed; verify_ok updates only on tgt_sum_valid, which can also set mismatch
   wire id_match = (file_id_r[31:16] == target_id[31:16]) &&
                   (file_id_r[7:0] == target_id[7:0]);
   always @(posedge core_clk) begin
      if (sys_rst) begin
         id_ok       <= 1'b0;
         csum_ok     <= 1'b0;
         version_err <= 1'b0;
         image_ok    <= 1'b0;
         verify_ok   <= 1'b0;
         mismatch    <= 1'b0;
      end else begin
         if (parsed_r) begin
            id_ok       <= id_match;
            csum_ok     <= (file_csum == app_csum);
            version_err <= (version_r != `IMAGE_VERSION);
            image_ok    <= id_match && (file_csum == app_csum) &&
                           (version_r == `IMAGE_VERSION) && !range_err;
            mismatch    <= !id_match || (file_csum != app_csum);
         end
         if (tgt_sum_valid) begin
            verify_ok <= (tgt_sum == file_csum);
            if (tgt_sum != file_csum) begin
               mismatch <= 1'b1;
            end
         end
      end
   end

   // Fuse decisions: hold the file code until the target bit is read back
   always @(posedge core_clk) begin
      if (sys_rst) begin
         fuse_blow     <= 1'b0;
         fuse_blow_idx <= 12'h000;
      end else begin
         fuse_blow <= 1'b0;
         // Blow only when target reads 0 and file asks for blown
         if (fuse_rd_valid && fuse_pending_r && !fuse_rd_bit && id_ok &&
             fuse_code_r[0] == `FUSE_BLOWN) begin
            fuse_blow     <= 1'b1;
            fuse_blow_idx <= fuse_rd_idx;
         end
      end
   end

   // Latest fuse byte from the stream; ignore and unblown take no action
   always @(posedge core_clk) begin
      if (sys_rst) begin
         fuse_code_r[0] <= `FUSE_IGNORE;
         fuse_pending_r <= 1'b0;
      end else if (img_valid && sec_nxt == SEC_FUSE) begin
         fuse_code_r[0] <= img_byte;
         fuse_pending_r <= 1'b1;
      end else if (fuse_rd_valid) begin
         fuse_pending_r <= 1'b0;
      end
   end

   // Bank ordering
   always @* begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (op_start) begin
               state_nxt = op_erase ? ST_EEXT : ST_PINT;
            end
         end
         ST_PINT: if (bank_done) state_nxt = ST_PEXT;
         ST_PEXT: if (bank_done) state_nxt = ST_DONE;
         ST_EEXT: if (bank_done) state_nxt = ST_EINT;
         ST_EINT: if (bank_done) state_nxt = ST_DONE;
         ST_DONE: state_nxt = ST_IDLE;
         default: state_nxt = ST_IDLE;
      endcase
   end

   always @(posedge core_clk) begin
      if (sys_rst) begin
         state_r  <= ST_IDLE;
         bank_req <= 1'b0;
         bank_sel <= 2'h0;
         done     <= 1'b0;
      end else begin
         state_r  <= state_nxt;
         done     <= (state_nxt == ST_DONE);
         bank_req <= (state_nxt == ST_PINT || state_nxt == ST_PEXT ||
                      state_nxt == ST_EEXT || state_nxt == ST_EINT);
         case (state_nxt)
            ST_PINT, ST_EINT: bank_sel <= BANK_INT;
            ST_PEXT, ST_EEXT: bank_sel <= BANK_EXT;
            default:          bank_sel <= 2'h0;
         endcase
      end
   end
endmodule // hex_image_checker

// ===== hdl/meta_store.v
/*
 * Twelve-byte store for the metadata section, written byte by byte and read
 * back with registered data. Assumes one clock and a synchronous reset.
 */
`timescale 1ns/1ps
module meta_store (
   core_clk,
   sys_rst,
   wr_en,
   wr_idx,
   wr_data,
   rd_idx,
   rd_data
);
   input  wire       core_clk;
   input  wire       sys_rst;
   input  wire       wr_en;
   input  wire [3:0] wr_idx;
   input  wire [7:0] wr_data;
   input  wire [3:0] rd_idx;
   output reg  [7:0] rd_data;

   reg [7:0] mem_r [0:11];
   integer   i;

   always @(posedge core_clk) begin
      if (sys_rst) begin
         for (i = 0; i < 12; i = i + 1) begin
            mem_r[i] <= 8'h00;
         end
         rd_data <= 8'h00;
      end else begin
         if (wr_en && (wr_idx < 4'hC)) begin
            mem_r[wr_idx] <= wr_data;
         end
         rd_data <= (rd_idx < 4'hC) ? mem_r[rd_idx] : 8'h00;
      end
   end
endmodule // meta_store

// ===== include/image_check_defs.vh
/*
 * Constants for the image checker: section bases in the image file address
 * space, section limits, metadata layout, one-time-fuse byte codes.
 * Assumes nothing; definitions only.
 */
`ifndef IMAGE_CHECK_DEFS_VH
`define IMAGE_CHECK_DEFS_VH

`define SEC_APP_BASE      32'h10000000
`define SEC_APP_MAX       32'h00200000
`define SEC_AUX_BASE      32'h14000000
`define SEC_AUX_MAX       32'h00008000
`define SEC_SUP_BASE      32'h16000000
`define SEC_SUP_END       32'h17FFFFFF
`define SEC_EXT_BASE      32'h18000000
`define SEC_EXT_END       32'h1FFFFFFF
`define SEC_EXT_MAX       32'h08000000
`define SEC_CSUM_BASE     32'h90300000
`define SEC_META_BASE     32'h90500000
`define SEC_META_LEN      32'h0000000C
`define SEC_FUSE_BASE     32'h90700000
`define SEC_FUSE_MAX      32'h00001000
`define BOOT_TABLE_BASE   32'h16006C00
`define BOOT_TABLE_LEN    32'h00000200

`define META_OFS_VER      4'h0
`define META_OFS_ID       4'h2
`define META_OFS_RSV0     4'h6
`define META_OFS_RSV1     4'h7
`define META_OFS_INT      4'h8
`define IMAGE_VERSION     16'h0005

`define FUSE_UNBLOWN      8'h00
`define FUSE_BLOWN        8'h01
`define FUSE_IGNORE       8'hFF

`define SUP_FRAG_MAX      3'h5

`endif

// ===== test/hex_image_checker_properties.sv
/* Port checker for hex_image_checker: section routing, sums, fuse and bank order.
   Assumes it is bound to the top module, one clock, synchronous reset. */
`timescale 1ns/1ps
`include "image_check_defs.vh"
module hex_image_checker_properties (
   input logic        core_clk,
   input logic        sys_rst,
   input logic        img_valid,
   input logic [31:0] img_addr,
   input logic [7:0]  img_byte,
   input logic        tgt_sum_valid,
   input logic [15:0] tgt_sum,
   input logic        fuse_rd_valid,
   input logic [11:0] fuse_rd_idx,
   input logic        fuse_rd_bit,
   input logic        op_start,
   input logic        op_erase,
   input logic [2:0]  sec_code,
   input logic [31:0] tgt_addr,
   input logic        tgt_we,
   input logic [7:0]  tgt_data,
   input logic        fuse_blow,
   input logic [11:0] fuse_blow_idx,
   input logic        bank_req,
   input logic [1:0]  bank_sel,
   input logic        id_ok,
   input logic        verify_ok,
   input logic        mismatch,
   input logic        range_err,
   input logic [15:0] file_csum,
   input logic [15:0] app_csum,
   input logic        done
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   wire app_a = img_addr >= `SEC_APP_BASE && img_addr < `SEC_APP_BASE + `SEC_APP_MAX;
   wire app_big = img_addr >= `SEC_APP_BASE + `SEC_APP_MAX && img_addr < `SEC_AUX_BASE;
   wire aux_big = img_addr >= `SEC_AUX_BASE + `SEC_AUX_MAX && img_addr < `SEC_SUP_BASE;
   wire ext_a = img_addr >= `SEC_EXT_BASE && img_addr <= `SEC_EXT_END;
   wire meta_a = img_addr >= `SEC_META_BASE && img_addr < `SEC_META_BASE + `SEC_META_LEN;
   AST_APP_WR: assert property (img_valid && app_a |=> tgt_we && sec_code == 3'h1
      && tgt_data == $past(img_byte) && tgt_addr == $past(img_addr))
      else $error("app byte not passed to target");
   AST_APP_SUM: assert property (img_valid && app_a |=>
      app_csum == $past(app_csum) + $past(img_byte)) else $error("app sum wrong");
   AST_APP_BIG: assert property (img_valid && app_big |=> !tgt_we && range_err)
      else $error("app overflow written");
   AST_AUX_BIG: assert property (img_valid && aux_big |=> !tgt_we && range_err)
      else $error("aux overflow written");
   AST_NO_WRITE: assert property (img_valid && img_addr >= `SEC_CSUM_BASE |=> !tgt_we)
      else $error("non-memory section written");
   AST_META_SEC: assert property (img_valid && meta_a |=> sec_code == 3'h6)
      else $error("metadata byte misclassified");
   AST_EXT_SEC: assert property (img_valid && ext_a |=> tgt_we && sec_code == 3'h4)
      else $error("external byte misrouted");
   AST_FUSE_BLOW: assert property (fuse_blow |-> $past(fuse_rd_valid) && !$past(fuse_rd_bit)
      && fuse_blow_idx == $past(fuse_rd_idx) && id_ok) else $error("bad fuse blow");
   AST_VERIFY: assert property (tgt_sum_valid && tgt_sum != file_csum |=> mismatch
      && !verify_ok) else $error("verify miss not flagged");
   AST_PROG_ORD: assert property (op_start && !op_erase && !bank_req |->
      ##[1:3] (bank_req && bank_sel == 2'h1)) else $error("program not internal first");
   AST_ERASE_ORD: assert property (op_start && op_erase && !bank_req |->
      ##[1:3] (bank_req && bank_sel == 2'h2)) else $error("erase not external first");
   COV_BLOW: cover property (fuse_blow);
   COV_DONE: cover property (done);
   COV_RANGE: cover property ($rose(range_err));
endmodule // hex_image_checker_properties

bind hex_image_checker hex_image_checker_properties chk (.core_clk, .sys_rst, .img_valid,
   .img_addr, .img_byte, .tgt_sum_valid, .tgt_sum, .fuse_rd_valid, .fuse_rd_idx, .fuse_rd_bit,
   .op_start, .op_erase, .sec_code, .tgt_addr, .tgt_we, .tgt_data, .fuse_blow, .fuse_blow_idx,
   .bank_req, .bank_sel, .id_ok, .verify_ok, .mismatch, .range_err, .file_csum, .app_csum,
   .done);

// ===== test/hex_image_checker_tb.sv
/* Self-checking bench for hex_image_checker with a target model.
   Assumes the design header on the include path; inputs change on falling edges. */
`timescale 1ns/1ps
`include "image_check_defs.vh"
module hex_image_checker_tb;
   localparam [31:0] SIL_ID = 32'h5A3C0102; // Arbitrary identity value
   reg         core_clk = 1'h0, sys_rst = 1'h1, img_valid = 1'h0, img_last = 1'h0;
   reg  [31:0] img_addr = 32'h0;
   reg  [7:0]  img_byte = 8'h0;
   reg         tgt_sum_valid = 1'h0, fuse_rd_valid = 1'h0, op_start = 1'h0, op_erase = 1'h0;
   reg  [15:0] tgt_sum = 16'h0;
   reg  [11:0] fuse_rd_idx = 12'h0;
   reg  [3:0]  bank_lat = 4'h1;
   wire [31:0] target_id, tgt_addr;
   wire [15:0] file_csum, app_csum, flash_sum;
   wire [11:0] fuse_blow_idx;
   wire [7:0]  tgt_data;
   wire [2:0]  sec_code;
   wire [1:0]  bank_sel;
   wire        fuse_rd_bit, bank_done, tgt_we, fuse_blow, bank_req, image_ok, id_ok, csum_ok;
   wire        verify_ok, mismatch, range_err, version_err, done;
   integer     err_total = 0, check_count = 0, cyc = 0, i;
   reg         we_s;
   reg  [2:0]  sec_s;
   reg  [15:0] exp_sum;
   reg  [1:0]  sel0, sel1;
   hex_image_checker dut (.core_clk, .sys_rst, .img_valid, .img_addr, .img_byte, .img_last,
      .target_id, .tgt_sum_valid, .tgt_sum, .fuse_rd_valid, .fuse_rd_idx, .fuse_rd_bit,
      .op_start, .op_erase, .bank_done, .sec_code, .tgt_addr, .tgt_we, .tgt_data, .fuse_blow,
      .fuse_blow_idx, .bank_req, .bank_sel, .image_ok, .id_ok, .csum_ok, .verify_ok,
      .mismatch, .range_err, .version_err, .file_csum, .app_csum, .done);
   target_model #(.SIL_ID(SIL_ID)) partner (.core_clk, .sys_rst, .tgt_we, .tgt_addr,
      .tgt_data, .fuse_blow, .fuse_blow_idx, .fuse_rd_idx, .bank_req, .bank_lat, .target_id,
      .fuse_rd_bit, .flash_sum, .bank_done);
   always #12.5 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      if (bank_done) begin
         sel1 <= sel0;
         sel0 <= bank_sel;
      end
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_total = err_total + 1;
         finish_test;
      end
   end
   task finish_test;
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task chk(input string nm, input [31:0] exp, input [31:0] got);
      check_count = check_count + 1;
      if (got !== exp) begin
         err_total = err_total + 1;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task do_reset;
      sys_rst = 1'h1;
      repeat (5) @(negedge core_clk);
      sys_rst = 1'h0;
   endtask
   // One byte per two cycles keeps every strobe edge in its own time step
   task send(input [31:0] a, input [7:0] d, input l);
      @(negedge core_clk);
      img_valid = 1'h1;
      img_addr = a;
      img_byte = d;
      img_last = l;
      @(negedge core_clk);
      img_valid = 1'h0;
      img_last = 1'h0;
      we_s = tgt_we;
      sec_s = sec_code;
   endtask
   task sec_try(input [31:0] a, input we, input [2:0] sc);
      send(a, 8'h5A, 1'h0);
      chk("tgt_we", we, we_s);
      chk("sec_code", sc, sec_s);
   endtask
   task t_sections;
      do_reset;
      sec_try(`SEC_APP_BASE + `SEC_APP_MAX - 1, 1'h1, 3'h1);
      sec_try(`SEC_AUX_BASE + `SEC_AUX_MAX - 1, 1'h1, 3'h2);
      sec_try(`SEC_SUP_BASE, 1'h1, 3'h3);
      sec_try(`BOOT_TABLE_BASE, 1'h1, 3'h3);
      sec_try(`SEC_EXT_END, 1'h1, 3'h4);
      sec_try(`SEC_CSUM_BASE, 1'h0, 3'h5);
      sec_try(`SEC_META_BASE + 4, 1'h0, 3'h6);
      sec_try(`SEC_FUSE_BASE, 1'h0, 3'h7);
      chk("range_err", 1'h0, range_err);
      send(`SEC_APP_BASE + `SEC_APP_MAX, 8'h11, 1'h0);
      chk("tgt_we", 1'h0, we_s);
      chk("range_err", 1'h1, range_err);
      do_reset;
      for (i = 0; i < 6; i = i + 1) begin
         send(`SEC_SUP_BASE + i * 32'h100, 8'h22, 1'h0);
         chk("tgt_we", i < 5, we_s);
      end
      chk("range_err", 1'h1, range_err);
   endtask
   task load_image(input [15:0] ver, input [31:0] idv, input [7:0] cadj);
      reg [95:0] mb;
      do_reset;
      exp_sum = 16'h0;
      for (i = 0; i < 260; i = i + 1) begin
         send(`SEC_APP_BASE + i, 8'hFF, 1'h0);
         exp_sum = exp_sum + 16'h00FF;
      end
      send(`SEC_CSUM_BASE, exp_sum[15:8], 1'h0);
      send(`SEC_CSUM_BASE + 1, exp_sum[7:0] + cadj, 1'h0);
      mb = {ver, idv, 8'hAA, 8'h55, 32'hC3A5_965A};
      for (i = 0; i < 12; i = i + 1) send(`SEC_META_BASE + i, mb[95 - 8 * i -: 8], i == 11);
      repeat (16) @(negedge core_clk);
      chk("app_csum", exp_sum, app_csum);
   endtask
   task pulse_sum(input [15:0] v);
      @(negedge core_clk);
      tgt_sum_valid = 1'h1;
      tgt_sum = v;
      @(negedge core_clk);
      tgt_sum_valid = 1'h0;
      @(negedge core_clk);
   endtask
   task fuse_try(input [11:0] idx, input [7:0] code, input blow);
      send(`SEC_FUSE_BASE + idx, code, 1'h0);
      @(negedge core_clk);
      fuse_rd_valid = 1'h1;
      fuse_rd_idx = idx;
      @(negedge core_clk);
      fuse_rd_valid = 1'h0;
      chk("fuse_blow", blow, fuse_blow);
      if (blow) chk("fuse_blow_idx", idx, fuse_blow_idx);
   endtask
   task bank_seq(input er, input [1:0] s0, input [1:0] s1);
      @(negedge core_clk);
      op_start = 1'h1;
      op_erase = er;
      @(negedge core_clk);
      op_start = 1'h0;
      for (i = 0; i < 200; i = i + 1) begin
         @(negedge core_clk);
         if (done === 1'h1) break;
      end
      chk("done", 1'h1, done);
      chk("first bank", s0, sel1);
      chk("second bank", s1, sel0);
   endtask
   task t_good;
      load_image(`IMAGE_VERSION, SIL_ID ^ 32'h0000_FF00, 8'h00);
      chk("id_ok", 1'h1, id_ok);
      chk("version_err", 1'h0, version_err);
      chk("csum_ok", 1'h1, csum_ok);
      chk("image_ok", 1'h1, image_ok);
      chk("file_csum", exp_sum, file_csum);
      chk("flash_sum", exp_sum, flash_sum);
      pulse_sum(flash_sum);
      chk("verify_ok", 1'h1, verify_ok);
      chk("mismatch", 1'h0, mismatch);
      fuse_try(12'h003, `FUSE_BLOWN, 1'h1);
      fuse_try(12'h003, `FUSE_BLOWN, 1'h0);
      fuse_try(12'h004, `FUSE_IGNORE, 1'h0);
      fuse_try(12'h005, `FUSE_UNBLOWN, 1'h0);
      fuse_try(12'hFFF, `FUSE_BLOWN, 1'h1);
      bank_seq(1'h0, 2'h1, 2'h2);
      bank_lat = 4'h9;
      bank_seq(1'h1, 2'h2, 2'h1);
      pulse_sum(flash_sum ^ 16'h0001);
      chk("mismatch", 1'h1, mismatch);
      chk("verify_ok", 1'h0, verify_ok);
   endtask
   task t_bad;
      load_image(16'h0004, SIL_ID ^ 32'h0000_0001, 8'h01);
      chk("id_ok", 1'h0, id_ok);
      chk("version_err", 1'h1, version_err);
      chk("csum_ok", 1'h0, csum_ok);
      chk("image_ok", 1'h0, image_ok);
      chk("mismatch", 1'h1, mismatch);
      fuse_try(12'h006, `FUSE_BLOWN, 1'h0);
   endtask
   initial begin
      sel0 = 2'h0;
      sel1 = 2'h0;
      t_sections;
      t_good;
      t_bad;
      finish_test;
   end
endmodule // hex_image_checker_tb

// ===== test/target_model.sv
/* Behavioural target: identity, fuse array, flash byte sum, bank completion.
   Assumes the checker's outputs on core_clk; bank latency set by the bench. */
`timescale 1ns/1ps
`include "image_check_defs.vh"
module target_model #(
   parameter [31:0] SIL_ID = 32'h5A3C0102 // Arbitrary identity value
) (
   input  wire        core_clk,
   input  wire        sys_rst,
   input  wire        tgt_we,
   input  wire [31:0] tgt_addr,
   input  wire [7:0]  tgt_data,
   input  wire        fuse_blow,
   input  wire [11:0] fuse_blow_idx,
   input  wire [11:0] fuse_rd_idx,
   input  wire        bank_req,
   input  wire [3:0]  bank_lat,
   output wire [31:0] target_id,
   output wire        fuse_rd_bit,
   output reg  [15:0] flash_sum = 16'h0,
   output reg         bank_done = 1'h0
);
   reg [4095:0] fuse_r = 4096'h0;
   reg [3:0]    wait_r = 4'h0;
   assign target_id = SIL_ID;
   assign fuse_rd_bit = fuse_r[fuse_rd_idx];
   always @(posedge core_clk) begin
      // Fuses survive reset and never clear once blown
      if (fuse_blow) fuse_r[fuse_blow_idx] <= 1'h1;
      if (sys_rst) begin
         flash_sum <= 16'h0;
         wait_r <= 4'h0;
         bank_done <= 1'h0;
      end else begin
         if (tgt_we && tgt_addr >= `SEC_APP_BASE && tgt_addr < `SEC_APP_BASE + `SEC_APP_MAX)
            flash_sum <= flash_sum + tgt_data;
         bank_done <= 1'h0;
         if (bank_req && !bank_done) begin
            wait_r <= wait_r + 4'h1;
            if (wait_r >= bank_lat) begin
               wait_r <= 4'h0;
               bank_done <= 1'h1;
            end
         end
      end
   end
endmodule // target_model
